//--- sse_consts.vh
// Purpose: Constants for the sequence stack entry bank.
// Assumes: 16-bit entries, 6-bit register address port.
// Notes:   Offsets, field positions, reset values and timing counts.
`ifndef SSE_CONSTS_VH
`define SSE_CONSTS_VH

// ==========================================================
// Register offsets
`define SSE_OFS_ENTRY_23     6'h37
`define SSE_OFS_ENTRY_24     6'h38
`define SSE_OFS_ENTRY_25     6'h39
`define SSE_OFS_ENTRY_26     6'h3A
`define SSE_OFS_SEQ_CTRL     6'h30
`define SSE_OFS_SEQ_STATUS   6'h31

// ==========================================================
// Reset values
`define SSE_RST_ENTRY_23     16'h6E00
`define SSE_RST_ENTRY_24     16'h7000
`define SSE_RST_ENTRY_25     16'h7200
`define SSE_RST_ENTRY_26     16'h7400
`define SSE_RST_SEQ_CTRL     1'h0

// ==========================================================
// Entry field positions
`define SSE_DIR_BIT          15
`define SSE_ADDR_HI          14
`define SSE_ADDR_LO          9
`define SSE_RET_BIT          8
`define SSE_CH2_HI           7
`define SSE_CH2_LO           4
`define SSE_CH1_HI           3
`define SSE_CH1_LO           0

// ==========================================================
// Control and status fields
`define SSE_CTRL_EN_BIT      0
`define SSE_STAT_IDX_LO      0
`define SSE_STAT_IDX_HI      1
`define SSE_STAT_RUN_BIT     2

// ==========================================================
// Sequencer geometry and timing
`define SSE_NUM_ENTRIES      4
`define SSE_FIRST_INDEX      2'h0
`define SSE_LAST_INDEX       2'h3
`define SSE_RD_LATENCY       1

`endif

//--- sse_entry.v
// Purpose: One 16-bit sequence stack entry register.
// Assumes: Synchronous active-low reset, single clock.
// Notes:   Reset value comes in as a parameter per entry.
`timescale 1ns/1ns
`default_nettype none

module sse_entry #(
  parameter [15:0] RESET_VALUE = 16'h0000
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  output wire [15:0] entry_q
);

  reg [15:0] value_q;

  // ========================================================
  // Storage
  // Every field is read/write, so the whole word is taken
  always @(posedge clk) begin
    if (!reset_n) begin
      value_q <= RESET_VALUE;
    end else if (wr_en) begin
      value_q <= wr_data;
    end
  end

  assign entry_q = value_q;

endmodule // sse_entry

`default_nettype wire

//--- sse_stack_bank.v
// Purpose: Bank of four sequence stack entries and the sequencer that
//          walks them, handing channel selects to both converters.
// Assumes: conv_done is a one-cycle pulse from logic on clk.
// Notes:   Register port: read data stand one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none

`include "sse_consts.vh"

// Summary of operation
// - Bit 15 holds access direction, read or write
// - Return flag clear: advance to next entry
// - Return flag set: jump back to first entry
// - Bits 7-4 select second converter channel
// - Bits 3-0 select first converter channel
// - Entry 24 at 0x38, resets to 0x7000
// - Entry 25 at 0x39, resets to 0x7200
// - Entry 26 at 0x3A, resets to 0x7400
// - Entry 23 at 0x37, resets to 0x6E00
module sse_stack_bank (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [5:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        conv_done,
  output reg  [3:0]  first_converter_channel,
  output reg  [3:0]  second_converter_channel,
  output reg  [1:0]  seq_index,
  output wire        seq_running
);

  // ========================================================
  // Declarations
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RUN  = 2'h1;

  wire [15:0] entry_w [0:`SSE_NUM_ENTRIES-1];
  wire [`SSE_NUM_ENTRIES-1:0] hit_w;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [1:0]  index_q;
  reg  [1:0]  index_d;
  reg         enable_q;
  reg  [15:0] rdata_d;
  wire [15:0] cur_entry_w;
  wire        ret_flag_w;
  wire        hit_ctrl_w;
  wire        hit_stat_w;

  // ========================================================
  // Entry registers
  // One instance per entry; reset value holds its own address
  genvar gi;
  generate
    for (gi = 0; gi < `SSE_NUM_ENTRIES; gi = gi + 1) begin : g_entry
      localparam [5:0] OFS = (gi == 0) ? `SSE_OFS_ENTRY_23 :
                             (gi == 1) ? `SSE_OFS_ENTRY_24 :
                             (gi == 2) ? `SSE_OFS_ENTRY_25 :
                                         `SSE_OFS_ENTRY_26;
      localparam [15:0] RST = (gi == 0) ? `SSE_RST_ENTRY_23 :
                              (gi == 1) ? `SSE_RST_ENTRY_24 :
                              (gi == 2) ? `SSE_RST_ENTRY_25 :
                                          `SSE_RST_ENTRY_26;
      // Decode by offset; the host supplies the address
      assign hit_w[gi] = (reg_addr == OFS);
      sse_entry #(
        .RESET_VALUE (RST)
      ) u_entry (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (reg_wr && hit_w[gi]),
        .wr_data (reg_wdata),
        .entry_q (entry_w[gi])
      );
    end
  endgenerate

  assign hit_ctrl_w = (reg_addr == `SSE_OFS_SEQ_CTRL);
  assign hit_stat_w = (reg_addr == `SSE_OFS_SEQ_STATUS);

  // ========================================================
  // Sequencer control register
  always @(posedge clk) begin
    if (!reset_n) begin
      enable_q <= `SSE_RST_SEQ_CTRL;
    end else if (reg_wr && hit_ctrl_w) begin
      enable_q <= reg_wdata[`SSE_CTRL_EN_BIT];
    end
  end

  // ========================================================
  // Read path
  // Unmapped addresses read zero; a read never stalls the host
  always @* begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      if (hit_w[0]) begin
        rdata_d = entry_w[0];
      end else if (hit_w[1]) begin
        rdata_d = entry_w[1];
      end else if (hit_w[2]) begin
        rdata_d = entry_w[2];
      end else if (hit_w[3]) begin
        rdata_d = entry_w[3];
      end else if (hit_ctrl_w) begin
        rdata_d[`SSE_CTRL_EN_BIT] = enable_q;
      end else if (hit_stat_w) begin
        rdata_d[`SSE_STAT_IDX_HI:`SSE_STAT_IDX_LO] = index_q;
        rdata_d[`SSE_STAT_RUN_BIT] = (state_q == ST_RUN);
      end
    end
  end

  // Data valid only in the cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // ========================================================
  // Sequencer
  // Entry being executed and its stack return flag
  assign cur_entry_w = entry_w[index_q];
  assign ret_flag_w  = cur_entry_w[`SSE_RET_BIT];

  // Step at most once per completed conversion. The bank ends
  // at its last entry, so stepping past it also closes the loop.
  always @* begin
    state_d = state_q;
    index_d = index_q;
    case (state_q)
      ST_IDLE: begin
        index_d = `SSE_FIRST_INDEX;
        if (enable_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable_q) begin
          state_d = ST_IDLE;
          index_d = `SSE_FIRST_INDEX;
        end else if (conv_done) begin
          if (ret_flag_w || index_q == `SSE_LAST_INDEX) begin
            index_d = `SSE_FIRST_INDEX;
          end else begin
            index_d = index_q + 2'h1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        index_d = `SSE_FIRST_INDEX;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      index_q <= `SSE_FIRST_INDEX;
    end else begin
      state_q <= state_d;
      index_q <= index_d;
    end
  end

  // ========================================================
  // Converter channel outputs
  // Registered so a host write to the live entry cannot glitch them
  always @(posedge clk) begin
    if (!reset_n) begin
      first_converter_channel  <= 4'h0;
      second_converter_channel <= 4'h0;
      seq_index                <= `SSE_FIRST_INDEX;
    end else begin
      first_converter_channel  <=
        entry_w[index_d][`SSE_CH1_HI:`SSE_CH1_LO];
      second_converter_channel <=
        entry_w[index_d][`SSE_CH2_HI:`SSE_CH2_LO];
      seq_index                <= index_d;
    end
  end

  assign seq_running = (state_q == ST_RUN);

endmodule // sse_stack_bank

`default_nettype wire

//--- sse_bank_props.sv
// Purpose: Assertions on the stack bank register port and sequencer.
// Assumes: Sees only the top ports; one clock, synchronous reset.
// Notes:   Bound to every bank instance after the module.
`timescale 1ns/1ns
`default_nettype none
module sse_bank_props (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [5:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        conv_done,
  input wire logic [3:0]  first_converter_channel,
  input wire logic [3:0]  second_converter_channel,
  input wire logic [1:0]  seq_index,
  input wire logic        seq_running
);
  // ==========================================================
  // Decodes used by the properties
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire ctl_wr = reg_wr && reg_addr == 6'h30;
  wire st_rd  = reg_rd && reg_addr == 6'h31;
  wire hole   = reg_addr < 6'h30 || (reg_addr > 6'h31 && reg_addr < 6'h37)
                || reg_addr > 6'h3A;
  // ==========================================================
  // Properties: read data only stand the cycle after a strobe; sequencer steps, holds, starts and stops
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_unmapped_rd: assert property (reg_rd && hole |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  a_step_one: assert property (conv_done && seq_running && !reg_wr |=>
    seq_index == $past(seq_index) + 2'h1 || seq_index == 2'h0)
    else $error("sequencer moved more than one entry");
  a_idle_hold: assert property (!seq_running && $past(!seq_running) &&
    !reg_wr |=> $stable(seq_index))
    else $error("index moved while stopped");
  a_start_first: assert property (ctl_wr && reg_wdata[0] && !seq_running
    |-> ##2 seq_running && seq_index == 2'h0)
    else $error("sequencer did not start at first entry");
  a_stop_run: assert property (ctl_wr && !reg_wdata[0] |-> ##[1:2] !seq_running)
    else $error("sequencer did not stop");
  a_stat_idx: assert property (st_rd |=> reg_rdata[2:0] ==
    {$past(seq_running), $past(seq_index)})
    else $error("status read disagrees with sequencer");
  a_stat_high: assert property (st_rd |=> reg_rdata[15:3] == 13'h0000)
    else $error("status upper bits not zero");
  // First cycle out of reset: stopped at the first entry, outputs clear
  a_reset_first: assert property ($rose(reset_n) |->
    reg_rdata == 16'h0000 && first_converter_channel == 4'h0 &&
    second_converter_channel == 4'h0 && seq_index == 2'h0 && !seq_running)
    else $error("outputs not in reset state after reset release");
  // Main scenarios
  c_step: cover property (conv_done && seq_running);
  c_last: cover property (seq_running && seq_index == 2'h3);
  c_stat: cover property (st_rd && seq_running);
endmodule // sse_bank_props

bind sse_stack_bank sse_bank_props i_sse_bank_props (.clk(clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_done(conv_done), .first_converter_channel(first_converter_channel),
  .second_converter_channel(second_converter_channel),
  .seq_index(seq_index), .seq_running(seq_running));
`default_nettype wire

//--- tb_sse_stack_bank.sv
// Purpose: Self-checking bench for the stack bank against an entry array and index model.
// Assumes: 125 MHz clock, reset held 16 cycles.
// Notes:   Entry words are random; return flags are forced for wraps.
`timescale 1ns/1ns
`default_nettype none
module tb_sse_stack_bank;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        conv_done = 1'b0;
  logic        run = 1'b0;
  logic [31:0] rs = 32'hD16F;
  logic [15:0] ent [4];
  wire  [15:0] reg_rdata;
  wire  [3:0]  ch_a;
  wire  [3:0]  ch_b;
  wire  [1:0]  seq_index;
  wire         seq_running;
  int          fails = 0;
  int          check_count = 0;
  int          idx = 0;

  // ==========================================================
  // Clock, design and helpers
  initial forever #4 clk = ~clk;

  sse_stack_bank i_sse_stack_bank (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .first_converter_channel(ch_a), .second_converter_channel(ch_b),
    .seq_index(seq_index), .seq_running(seq_running));

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(logic [5:0] a, logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(logic [5:0] a, logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", e, reg_rdata);
  endtask

  // One conversion done; the model moves the index by the return flag
  task automatic step();
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    if (run) idx = ent[idx][8] ? 0 : (idx + 1) % 4;
    @(negedge clk);
    chk("seq_index", 16'(idx), seq_index);
    chk("seq_running", 16'(run), 16'(seq_running));
    chk("ch_a", ent[idx][3:0], ch_a);
    chk("ch_b", ent[idx][7:4], ch_b);
  endtask

  task automatic end_sim();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    fails++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) ent[i] = 16'h6E00 + 16'(i * 16'h0200);
    for (int i = 0; i < 4; i++) rd(6'h37 + 6'(i), ent[i]);
    rd(6'h31, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      ent[i] = rs[15:0];
      wr(6'h37 + 6'(i), ent[i]);
    end
    wr(6'h3F, 16'hFFFF);
    wr(6'h31, 16'hFFFF);
    for (int i = 0; i < 4; i++) rd(6'h37 + 6'(i), ent[i]);
    rd(6'h3F, 16'h0000);
    step();
    wr(6'h30, 16'h0001);
    run = 1'b1;
    repeat (2) @(posedge clk);
    rd(6'h31, 16'h0004);
    rd(6'h30, 16'h0001);
    repeat (10) step();
    // Return at entry 24, plain advance everywhere else
    for (int i = 0; i < 4; i++) ent[i][8] = (i == 1);
    for (int i = 0; i < 4; i++) wr(6'h37 + 6'(i), ent[i]);
    repeat (6) step();
    rd(6'h31, {13'h0001, 1'b0, 2'(idx)} ^ 16'h000C);
    wr(6'h30, 16'h0000);
    run = 1'b0;
    idx = 0;
    repeat (2) @(posedge clk);
    rd(6'h31, 16'h0000);
    step();
    // Reset in mid-run: entries and sequencer fall back to reset state
    wr(6'h30, 16'h0001);
    run = 1'b1;
    repeat (2) @(posedge clk);
    repeat (3) step();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    run = 1'b0;
    idx = 0;
    for (int i = 0; i < 4; i++) ent[i] = 16'h6E00 + 16'(i * 16'h0200);
    for (int i = 0; i < 4; i++) rd(6'h37 + 6'(i), ent[i]);
    rd(6'h31, 16'h0000);
    step();
    end_sim();
  end
endmodule // tb_sse_stack_bank
`default_nettype wire
